// ===== common/tx_sink_params.svh
// Purpose: Constants of the transmit client packet sink
// Assumes: 40 Gb variant, four 64-bit words on the client bus
// Notes:   Definitions only
`ifndef TX_SINK_PARAMS_SVH
`define TX_SINK_PARAMS_SVH

`define WORD_W                64
`define BUS_WORDS             4
`define DATA_W                (`BUS_WORDS * `WORD_W)
`define BUS_BYTES             (`BUS_WORDS * 8)
`define EMPTY_W               5
`define FIFO_DEPTH            8
`define START_BYTE            8'hFB
`define ACCEPT_DELAY_CYCLES   0
`define PREAMBLE_CFG_OFFSET   12'h125
`define PREAMBLE_CFG_BIT      1

`endif

// ===== common/tx_sink_pkg.sv
// Purpose: Types of the transmit client packet sink
// Assumes: Constants come from tx_sink_params.svh
// Notes:   One beat is what the client hands over in one accepted cycle
`include "tx_sink_params.svh"

package tx_sink_pkg;

  typedef struct packed {
    logic [`DATA_W-1:0]  data;
    logic [`EMPTY_W-1:0] empty;
    logic                sop;
    logic                eop;
    logic                err;
  } beat_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_PKT  = 1'b1
  } pkt_state_t;

endpackage : tx_sink_pkg

// ===== common/beat_if.sv
// Purpose: Valid/ready carrier for beats between the sink and its FIFO
// Assumes: One clock for both ends
// Notes:   src drives valid and data, snk drives ready
`timescale 1ns/1ps

interface beat_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : beat_if

// ===== rtl/beat_fifo.sv
// Purpose: Synchronous FIFO of beats with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   Read data is the head entry, shown combinationally
`timescale 1ns/1ps

module beat_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  beat_if.snk       in_b,
  beat_if.src       out_b
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_ptr_r;
  logic [AW:0]  rd_ptr_r;
  logic         full;
  logic         empty;
  logic         push;
  logic         pop;

  assign empty       = (wr_ptr_r == rd_ptr_r);
  assign full        = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  assign in_b.ready  = !full;
  assign out_b.valid = !empty;
  assign out_b.data  = mem[rd_ptr_r[AW-1:0]];
  assign push        = in_b.valid && !full;
  assign pop         = out_b.ready && !empty;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_r[AW-1:0]] <= in_b.data;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_ptr_r <= '0;
    end else if (push) begin
      wr_ptr_r <= wr_ptr_r + 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rd_ptr_r <= '0;
    end else if (pop) begin
      rd_ptr_r <= rd_ptr_r + 1'b1;
    end
  end

  chk_full_refuses: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    full |-> !in_b.ready && (wr_ptr_r - rd_ptr_r) == (AW+1)'(DEPTH))
    else $error("FIFO full flag disagrees with occupancy");
endmodule : beat_fifo

// ===== rtl/eth_mac_tx_client_packet_sink.sv
// Purpose: Transmit client packet sink of the MAC, wide-bus side
// Assumes: Client logic runs on clk_i; lanes-stable comes from the PHY side
// Notes:   Beats are buffered in an 8-entry FIFO ahead of the MAC datapath
// Contract
// RL1: All interface signals timed by one clock
// RL2: Bus is four 64-bit words wide
// RL3: Client places preamble first when pass-through on
// RL4: Client sends packet data without idle gaps
// RL5: Client holds valid from start to end
// RL6: Empty count gives unused bytes at end
// RL7: Packet starts in the most significant byte
// RL8: End marker cycle is the packet's last
// RL9: Ready high means data accepted that cycle
// RL10: Client holds valid and data until ready
// RL11: Client waits for lanes stable after reset
// RL12: Error at end corrupts the packet
// RL13: Corrupted packet flagged malformed on loopback
// RL14: Client is source, MAC is sink
// RL15: Pass-through replaces start byte, keeps rest
// RL16: Empty and error ignored outside end cycle
`timescale 1ns/1ps
`include "tx_sink_params.svh"

module eth_mac_tx_client_packet_sink
  import tx_sink_pkg::*;
(
  input  wire logic                clk_i,
  input  wire logic                reset_n_i,
  input  wire logic [`DATA_W-1:0]  tx_data_i,
  input  wire logic [`EMPTY_W-1:0] tx_empty_i,
  input  wire logic                tx_sop_i,
  input  wire logic                tx_eop_i,
  input  wire logic                tx_valid_i,
  input  wire logic                tx_error_i,
  output logic                     tx_ready_o,
  input  wire logic                tx_lanes_stable_i,
  input  wire logic                preamble_pass_en_i,
  input  wire logic                loopback_en_i,
  output logic [`DATA_W-1:0]       out_data_o,
  output logic [`EMPTY_W-1:0]      out_empty_o,
  output logic                     out_sop_o,
  output logic                     out_eop_o,
  output logic                     out_error_o,
  output logic                     out_valid_o,
  input  wire logic                out_ready_i,
  output logic                     loop_malformed_o,
  output logic                     pkt_active_o
);
  localparam int BW = $bits(beat_t);

  beat_if #(.W(BW)) in_b  ();
  beat_if #(.W(BW)) out_b ();

  logic                stable_meta_r;
  logic                stable_sync_r;
  logic                accept;
  logic                corrupt;
  logic [`DATA_W-1:0]  corrupt_mask;
  beat_t               in_beat;
  beat_t               head_beat;
  beat_t               out_q_r;
  logic                out_valid_r;
  logic                loop_malformed_r;
  pkt_state_t          pkt_state_r;
  pkt_state_t          pkt_state_nxt;

  // Lanes-stable crosses in from the PHY side
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stable_meta_r <= 1'b0;
      stable_sync_r <= 1'b0;
    end else begin
      stable_meta_r <= tx_lanes_stable_i;
      stable_sync_r <= stable_meta_r;
    end
  end

  // Zero accept delay: ready and acceptance share the same cycle
  assign tx_ready_o = in_b.ready && stable_sync_r; // RL9
  assign accept     = tx_valid_i && tx_ready_o; // RL9
  assign in_b.valid = tx_valid_i && stable_sync_r;
  assign corrupt    = tx_eop_i && tx_error_i; // RL12

  // Flip the last used byte of the end beat
  for (genvar b = 0; b < `BUS_BYTES; b++) begin : g_byte
    assign corrupt_mask[b*8 +: 8] =
      (corrupt && tx_empty_i == (`EMPTY_W)'(b)) ? 8'hFF : 8'h00; // RL2 RL6 RL12
  end

  always_comb begin
    in_beat      = '0;
    in_beat.data = tx_data_i ^ corrupt_mask; // RL7
    if (tx_sop_i && preamble_pass_en_i) begin
      in_beat.data[`DATA_W-1 -: 8] = `START_BYTE; // RL15
    end
    in_beat.sop = tx_sop_i;
    in_beat.eop = tx_eop_i; // RL8
    if (tx_eop_i) begin
      in_beat.empty = tx_empty_i; // RL16
      in_beat.err   = tx_error_i; // RL16
    end
  end

  assign in_b.data = in_beat;

  beat_fifo #(
    .W     (BW),
    .DEPTH (`FIFO_DEPTH)
  ) u_fifo (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .in_b      (in_b.snk),
    .out_b     (out_b.src)
  );

  // Packet tracking; end beat closes the packet
  always_comb begin
    pkt_state_nxt = pkt_state_r;
    case (pkt_state_r)
      ST_IDLE: begin
        if (accept && tx_sop_i && !tx_eop_i) begin
          pkt_state_nxt = ST_PKT;
        end
      end
      ST_PKT: begin
        if (accept && tx_eop_i) begin
          pkt_state_nxt = ST_IDLE; // RL8
        end
      end
      default: pkt_state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pkt_state_r <= ST_IDLE;
    end else begin
      pkt_state_r <= pkt_state_nxt; // RL1
    end
  end

  assign pkt_active_o = (pkt_state_r == ST_PKT);

  // Output register toward the MAC datapath
  assign head_beat   = beat_t'(out_b.data);
  assign out_b.ready = !out_valid_r || out_ready_i; // RL14

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      out_valid_r <= 1'b0;
    end else if (out_b.ready) begin
      out_valid_r <= out_b.valid;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      out_q_r <= '0;
    end else if (out_b.ready && out_b.valid) begin
      out_q_r <= head_beat;
    end
  end

  // Corrupted packet leaving on loopback is reported malformed
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      loop_malformed_r <= 1'b0;
    end else begin
      loop_malformed_r <= loopback_en_i && out_valid_r && out_ready_i
                          && out_q_r.eop && out_q_r.err; // RL13
    end
  end

  assign out_data_o       = out_q_r.data;
  assign out_empty_o      = out_q_r.empty;
  assign out_sop_o        = out_q_r.sop;
  assign out_eop_o        = out_q_r.eop;
  assign out_error_o      = out_q_r.err;
  assign out_valid_o      = out_valid_r;
  assign loop_malformed_o = loop_malformed_r;

  // Interface and datapath checks
  chk_ready_needs_lanes: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RL11
    !$past(tx_lanes_stable_i, 2) |-> !tx_ready_o) else $error("Ready high before lanes stable");

  chk_accept_same_cycle: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RL9
    accept |=> out_b.valid) else $error("Accepted beat not pushed");

  chk_start_byte_swap: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RL15
    accept && tx_sop_i && preamble_pass_en_i |->
      in_beat.data[`DATA_W-1 -: 8] == `START_BYTE
      && (in_beat.data[`DATA_W-9:`DATA_W-64] ^ tx_data_i[`DATA_W-9:`DATA_W-64])
         == corrupt_mask[`DATA_W-9:`DATA_W-64])
    else $error("Start byte not replaced");

  chk_data_passes: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RL7
    accept && !preamble_pass_en_i && !corrupt |-> in_beat.data == tx_data_i)
    else $error("Clean beat data altered");

  chk_fields_ignored: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RL16
    accept && !tx_eop_i |-> in_beat.empty == '0 && !in_beat.err)
    else $error("Empty or error kept outside end beat");

  chk_corrupt_byte: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RL12
    accept && corrupt && !tx_sop_i |->
      (in_beat.data ^ tx_data_i) == ((`DATA_W)'(8'hFF) << {tx_empty_i, 3'b000}))
    else $error("Wrong byte corrupted");

  chk_eop_closes: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RL8
    accept && tx_eop_i |=> pkt_state_r == ST_IDLE) else $error("Packet open after end");

  chk_malformed_flag: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RL13
    loopback_en_i && out_valid_o && out_ready_i && out_eop_o && out_error_o
      |=> loop_malformed_o) else $error("Malformed flag missing");

  chk_out_held: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RL14
    out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o)
      && $stable(out_eop_o)) else $error("Output changed while stalled");

  chk_sop_opens: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RL8
    accept && tx_sop_i && !tx_eop_i |=> pkt_active_o) else $error("Packet not opened");

  chk_mid_fields_zero: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RL16
    out_valid_o && !out_eop_o |-> out_empty_o == '0 && !out_error_o)
    else $error("Empty or error leaked on mid beat");

  chk_malformed_only: assert property (@(posedge clk_i) disable iff (!reset_n_i) // RL13
    !(loopback_en_i && out_valid_o && out_ready_i && out_eop_o && out_error_o)
      |=> !loop_malformed_o) else $error("Malformed flag without cause");
endmodule : eth_mac_tx_client_packet_sink

// ===== test/client_src.sv
// Purpose: Client source model that hands transmit beats to the sink
// Assumes: Signals change 1 ns after rising edges of clk_i
// Notes:   A released bus shows inverted last data
`timescale 1ns/1ps
`include "tx_sink_params.svh"

module client_src
  import tx_sink_pkg::*;
(
  input  wire logic           clk_i,
  input  wire logic           ready_i,
  output logic [`DATA_W-1:0]  data_o,
  output logic [`EMPTY_W-1:0] empty_o,
  output logic                sop_o,
  output logic                eop_o,
  output logic                valid_o,
  output logic                error_o
);
  initial {data_o, empty_o, sop_o, eop_o, error_o, valid_o} = '0;

  // Held until taken, next beat follows at once
  task automatic send(input beat_t b, output logic ok);
    int n;
    n = 0;
    {data_o, empty_o, sop_o, eop_o, error_o} = b;
    valid_o = 1'b1;
    while (ready_i !== 1'b1 && n < 50) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    ok = (n < 50);
    @(posedge clk_i);
    #1;
  endtask : send

  task automatic idle();
    valid_o = 1'b0;
    data_o  = ~data_o;
    sop_o   = 1'b0;
    eop_o   = 1'b0;
  endtask : idle
endmodule : client_src

// ===== test/eth_mac_tx_client_packet_sink_tb.sv
// Purpose: Self-checking bench of the transmit client packet sink
// Assumes: 40 MHz clock, beats driven 1 ns after rising edges
// Notes:   MAC-side beats are collected whenever valid and ready meet
`timescale 1ns/1ps
`include "tx_sink_params.svh"

module eth_mac_tx_client_packet_sink_tb;
  import tx_sink_pkg::*;
  logic clk_i = 0, reset_n = 0, lanes = 0, pass = 0, lpb = 0, ordy = 1;
  logic [`DATA_W-1:0] td, od;
  logic [`EMPTY_W-1:0] te, oe;
  logic ts, tq, tv, tr, rdy, os, oq, oerr, ov, mal, act;
  int err_count = 0, checks_done = 0, mal_cnt = 0;
  beat_t got[$], want[$];

  always #12.5 clk_i = ~clk_i;

  client_src src (.clk_i(clk_i), .ready_i(rdy), .data_o(td), .empty_o(te), .sop_o(ts),
    .eop_o(tq), .valid_o(tv), .error_o(tr));

  eth_mac_tx_client_packet_sink dut (.clk_i(clk_i), .reset_n_i(reset_n), .tx_data_i(td),
    .tx_empty_i(te), .tx_sop_i(ts), .tx_eop_i(tq), .tx_valid_i(tv), .tx_error_i(tr),
    .tx_ready_o(rdy), .tx_lanes_stable_i(lanes), .preamble_pass_en_i(pass),
    .loopback_en_i(lpb), .out_data_o(od), .out_empty_o(oe), .out_sop_o(os),
    .out_eop_o(oq), .out_error_o(oerr), .out_valid_o(ov), .out_ready_i(ordy),
    .loop_malformed_o(mal), .pkt_active_o(act));

  always @(posedge clk_i) begin
    if (ov === 1'b1 && ordy)
      got.push_back({od, oe, os, oq, oerr});
    if (mal === 1'b1)
      mal_cnt++;
  end

  task automatic check(string nm, logic [$bits(beat_t)-1:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s exp %0h seen %0h", nm, exp, seen);
    end
  endtask : check

  function automatic beat_t bt(int i, logic s, e, logic [4:0] em, logic er);
    bt = {{`BUS_WORDS{64'h0123_4567_89AB_CD00 + 64'(i)}}, em, s, e, er};
  endfunction : bt

  function automatic beat_t xp(beat_t b);
    xp = b;
    xp.err = b.eop & b.err;
    if (!b.eop)
      xp.empty = '0;
    if (b.eop && b.err)
      xp.data[b.empty*8 +: 8] = ~b.data[b.empty*8 +: 8];
    if (b.sop && pass)
      xp.data[255:248] = `START_BYTE;
  endfunction : xp

  task automatic put(beat_t b);
    logic ok;
    src.send(b, ok);
    check("send taken", ok, 1'b1);
    want.push_back(xp(b));
  endtask : put

  task automatic drain(string nm);
    int n;
    n = 0;
    while (got.size() < want.size() && n < 100) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    check({nm, " count"}, got.size(), want.size());
    foreach (want[i])
      check(nm, got[i], want[i]);
    got.delete();
    want.delete();
    $display("test %s done", nm);
  endtask : drain

  task automatic t_lanes();
    repeat (3) @(posedge clk_i);
    #1;
    check("ready before lanes", rdy, 1'b0);
    lanes = 1'b1;
    @(posedge clk_i);
    #1;
    check("ready one edge", rdy, 1'b0);
    repeat (3) @(posedge clk_i);
    #1;
    check("ready up", rdy, 1'b1);
    $display("test lanes done");
  endtask : t_lanes

  task automatic t_basic();
    put(bt(1, 1, 0, 5'h07, 1));
    check("active", act, 1'b1);
    put(bt(2, 0, 1, 5'h05, 0));
    check("active end", act, 1'b0);
    put(bt(3, 1, 1, 5'h00, 0));
    src.idle();
    drain("basic");
  endtask : t_basic

  task automatic t_err();
    beat_t b;
    pass = 1'b1;
    lpb  = 1'b1;
    b = bt(4, 1, 0, 5'h00, 0);
    b.data[255:192] = 64'h0055_5555_5555_55D5;
    put(b);
    put(bt(5, 0, 1, 5'h03, 1));
    put(bt(6, 1, 1, 5'h1F, 1));
    src.idle();
    drain("error pass");
    repeat (3) @(posedge clk_i);
    #1;
    check("malformed", mal_cnt, 2);
    pass = 1'b0;
    lpb  = 1'b0;
  endtask : t_err

  task automatic t_full();
    ordy = 1'b0;
    for (int i = 0; i < 9; i++)
      put(bt(10 + i, 1, 1, 5'(i), 0));
    check("ready full", rdy, 1'b0);
    fork
      put(bt(19, 1, 1, 5'h09, 0));
      begin
        repeat (4) @(posedge clk_i);
        #1;
        ordy = 1'b1;
      end
    join
    src.idle();
    drain("full");
    check("ready drained", rdy, 1'b1);
  endtask : t_full

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test

  initial begin
    #100000;
    err_count++;
    finish_test();
  end

  initial begin
    repeat (3) @(posedge clk_i);
    #1;
    check("reset ready", rdy, 1'b0);
    check("reset valid", ov, 1'b0);
    reset_n = 1'b1;
    t_lanes();
    t_basic();
    t_err();
    t_full();
    finish_test();
  end
endmodule : eth_mac_tx_client_packet_sink_tb
